//--- pbops_pkg.sv
/*
 * constants, opcodes and state encodings for the page-buffer command block.
 * assumes one 25 MHz core clock; the serial link clock is sampled as data.
 */
package pbops_pkg;
    localparam logic [7:0] OP_LOAD_B1 = 8'h53;
    localparam logic [7:0] OP_LOAD_B2 = 8'h55;
    localparam logic [7:0] OP_COMP_B1 = 8'h60;
    localparam logic [7:0] OP_COMP_B2 = 8'h61;
    localparam logic [7:0] OP_REWR_B1 = 8'h58;
    localparam logic [7:0] OP_REWR_B2 = 8'h59;
    localparam logic [7:0] OP_STATUS = 8'hd7;
    // density code value is arbitrary
    localparam logic [3:0] DENSITY_CODE = 4'h5;
    localparam int STS_RDY_BIT = 7;
    localparam int STS1_COMP_BIT = 6;
    localparam int STS2_FAULT_BIT = 5;
    localparam int PAGE_W = 12;
    localparam int PG264_LSB = 9;
    localparam int PG256_LSB = 8;
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [8:0] STAGE_IDX_RST = 9'h000;
    // request kinds toward the array
    localparam logic [1:0] ARR_FETCH = 2'h0;
    localparam logic [1:0] ARR_COMPARE = 2'h1;
    localparam logic [1:0] ARR_PROGRAM = 2'h2;
    localparam logic [1:0] ARR_FETCH_MERGE = 2'h3;

    typedef enum logic [1:0] {
        PBOPS_OP_LOAD = 2'h0,
        PBOPS_OP_COMP = 2'h1,
        PBOPS_OP_REWR = 2'h3,
        PBOPS_OP_RMW = 2'h2
    } pbops_op_t;

    typedef enum logic [2:0] {
        SPI_IDLE = 3'h0,
        SPI_OPC = 3'h1,
        SPI_ADDR = 3'h3,
        SPI_DATA = 3'h2,
        SPI_STAT = 3'h6,
        SPI_SKIP = 3'h7
    } pbops_spi_t;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'h0,
        ENG_FETCH = 2'h1,
        ENG_PROG = 2'h3
    } pbops_eng_t;
endpackage : pbops_pkg

//--- pbops_eng_if.sv
/*
 * carrier between the serial command front end and the operation engine.
 * assumes both ends run on core_clk.
 */
`timescale 1ns/100ps
interface pbops_eng_if;
    import pbops_pkg::*;
    logic start;
    pbops_op_t op;
    logic buf2;
    logic [PAGE_W-1:0] page;
    logic busy;
    logic comp_miss;
    logic pe_fault;
    modport seq (output start, op, buf2, page, input busy, comp_miss, pe_fault);
    modport eng (input start, op, buf2, page, output busy, comp_miss, pe_fault);
endinterface : pbops_eng_if

//--- pbops_engine.sv
/*
 * self-timed page operation engine: load, compare, rewrite, read-modify-write.
 * assumes the array answers each request with one done pulse on core_clk.
 */
`timescale 1ns/100ps
module pbops_engine
    import pbops_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic rst, // sync reset, high
    pbops_eng_if.eng ctl, // commands from front end
    output logic arr_req, // array request pulse
    output logic [1:0] arr_kind, // array request kind
    output logic arr_buf2, // buffer two selected
    output logic [PAGE_W-1:0] arr_page, // page index
    input wire logic arr_done, // array operation done
    input wire logic arr_mismatch, // compare found a difference
    input wire logic arr_fault, // program failed
    input wire logic arr_abort // operation aborted
);
    typedef struct packed {
        pbops_eng_t st;
        pbops_op_t op;
        logic req;
        logic [1:0] kind;
        logic buf2;
        logic [PAGE_W-1:0] page;
        logic comp;
        logic fault;
    } pbops_eng_state_t;

    pbops_eng_state_t q, d;

    always_comb begin
        d = q;
        d.req = 1'b0;
        unique case (q.st)
            ENG_IDLE: begin
                if (ctl.start) begin // [R05]
                    d.op = ctl.op;
                    d.buf2 = ctl.buf2;
                    d.page = ctl.page;
                    d.req = 1'b1;
                    d.st = ENG_FETCH;
                    unique case (ctl.op)
                        PBOPS_OP_COMP: d.kind = ARR_COMPARE; // [R07]
                        PBOPS_OP_RMW: d.kind = ARR_FETCH_MERGE; // [R11]
                        default: d.kind = ARR_FETCH;
                    endcase
                end
            end
            ENG_FETCH: begin
                if (arr_done) begin
                    d.st = ENG_IDLE;
                    if (q.op == PBOPS_OP_COMP && !arr_abort) begin
                        d.comp = arr_mismatch; // [R08]
                    end
                    if ((q.op == PBOPS_OP_REWR || q.op == PBOPS_OP_RMW) && !arr_abort) begin
                        d.st = ENG_PROG; // [R10]
                        d.kind = ARR_PROGRAM;
                        d.req = 1'b1;
                    end
                end
            end
            ENG_PROG: begin
                if (arr_done) begin
                    d.st = ENG_IDLE;
                    d.fault = arr_fault & ~arr_abort; // [R23] [R21]
                end
            end
            default: d.st = ENG_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '{st: ENG_IDLE, op: PBOPS_OP_LOAD, kind: ARR_FETCH, page: '0, default: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign ctl.busy = (q.st != ENG_IDLE);
    assign ctl.comp_miss = q.comp;
    assign ctl.pe_fault = q.fault;
    assign arr_req = q.req;
    assign arr_kind = q.kind;
    assign arr_buf2 = q.buf2;
    assign arr_page = q.page;

    sequence s_fetch_ok;
        q.st == ENG_FETCH && arr_done && !arr_abort && q.op == PBOPS_OP_REWR;
    endsequence
    sequence s_prog_go;
        q.st == ENG_PROG && arr_req && arr_kind == ARR_PROGRAM;
    endsequence
    a_rewrite_two_step: assert property (@(posedge core_clk) disable iff (rst) // [R10]
        s_fetch_ok |=> s_prog_go) else $error("rewrite did not program after fetch");
    a_busy_after_start: assert property (@(posedge core_clk) disable iff (rst) // [R05]
        ctl.start && !ctl.busy |=> ctl.busy && arr_req) else $error("not busy after start");
    a_compare_result: assert property (@(posedge core_clk) disable iff (rst) // [R08]
        q.st == ENG_FETCH && q.op == PBOPS_OP_COMP && arr_done && !arr_abort
        |=> ctl.comp_miss == $past(arr_mismatch) && !ctl.busy) else $error("compare result lost");
    a_fault_abort_clear: assert property (@(posedge core_clk) disable iff (rst) // [R23]
        q.st == ENG_PROG && arr_done && arr_abort |=> !ctl.pe_fault) else $error("fault set on abort");
endmodule : pbops_engine

//--- pbops_top.sv
/*
 * serial command front end: decodes page load, compare, rewrite and status read.
 * assumes mode 0 link; pins are asynchronous and pass two flip-flops.
 */
`timescale 1ns/100ps
// Function
// R01: opcodes 53h/55h load page into buffer
// R02: 264-byte pages: 3 dummy, 12 page, 9 dummy
// R03: 256-byte pages: 4 dummy, 12 page, 8 dummy
// R04: operation starts only on chip select rise
// R05: busy flag shown throughout page load
// R06: opcodes 60h/61h compare page against buffer
// R07: compare runs on chip select rise, busy
// R08: compare result into byte one bit 6
// R09: opcodes 58h/59h rewrite page in place
// R10: rewrite fetches then programs, staying busy
// R11: data after address turns rewrite into merge
// R12: host refreshes sector pages every 50,000 cycles
// R13: opcode D7h streams status on SO
// R14: status readable at any time, even busy
// R15: two status bytes repeat, sampled afresh
// R16: bit 7 of both bytes is ready
// R17: chip select release floats SO immediately
// R18: byte one bits 5:2 hold density code
// R19: byte one bit 1 shows protection enabled
// R20: byte one bit 0 shows 256-byte pages
// R21: byte two bit 5 flags program fault
// R22: byte two bits 6,4,3 read zero
// R23: fault updated per operation, clear on abort
// R24: host waits for ready before next command
module pbops_top
    import pbops_pkg::*;
(
    input wire logic core_clk, // core clock, 25 MHz
    input wire logic rst, // sync reset, high
    input wire logic cs_n_pin, // chip select pin, low active
    input wire logic sck_pin, // serial clock pin
    input wire logic si_pin, // serial data in pin
    output logic so_o, // serial data out
    output logic so_oe, // serial data out enable
    input wire logic sector_protect_en, // protection enabled
    input wire logic page_cfg_256, // 256-byte page configuration
    output logic stage_wr, // merge byte strobe
    output logic [8:0] stage_idx, // merge byte position
    output logic [7:0] stage_byte, // merge byte value
    output logic arr_req, // array request pulse
    output logic [1:0] arr_kind, // array request kind
    output logic arr_buf2, // buffer two selected
    output logic [PAGE_W-1:0] arr_page, // page index
    input wire logic arr_done, // array done pulse
    input wire logic arr_mismatch, // compare difference
    input wire logic arr_fault, // program failed
    input wire logic arr_abort // operation aborted
);
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic sck_s1;
        logic sck_s2;
        logic sck_prev;
        logic si_s1;
        logic si_s2;
        pbops_spi_t st;
        logic [2:0] bits;
        logic [1:0] bytes;
        logic [7:0] shreg;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic had_data;
        logic so;
        logic sts_sel;
        logic [7:0] sts_byte;
        logic stg_wr;
        logic [8:0] stg_idx;
        logic [7:0] stg_byte;
        logic start;
        pbops_op_t op;
        logic buf2;
        logic [PAGE_W-1:0] page;
    } pbops_fe_state_t;

    pbops_fe_state_t q, d;
    pbops_eng_if eng_bus ();

    function automatic logic is_page_cmd(input logic [7:0] opc);
        is_page_cmd = (opc == OP_LOAD_B1) || (opc == OP_LOAD_B2) || (opc == OP_COMP_B1)
                   || (opc == OP_COMP_B2) || (opc == OP_REWR_B1) || (opc == OP_REWR_B2);
    endfunction : is_page_cmd

    function automatic logic is_rewrite(input logic [7:0] opc);
        is_rewrite = (opc == OP_REWR_B1) || (opc == OP_REWR_B2);
    endfunction : is_rewrite

    logic sck_rise;
    logic sck_fall;
    logic ready;
    logic [7:0] sts1;
    logic [7:0] sts2;
    logic [7:0] shifted;

    assign sck_rise = q.sck_s2 & ~q.sck_prev;
    assign sck_fall = ~q.sck_s2 & q.sck_prev;
    // start cycle counts as busy, engine flags it one edge later
    assign ready = ~(eng_bus.busy | q.start); // [R16] [R05]
    assign sts1 = {ready, eng_bus.comp_miss, DENSITY_CODE, sector_protect_en, page_cfg_256}; // [R18] [R19] [R20]
    assign sts2 = {ready, 1'b0, eng_bus.pe_fault, 5'h00}; // [R21] [R22]
    assign shifted = {q.shreg[6:0], q.si_s2};

    always_comb begin
        d = q;
        d.cs_s1 = cs_n_pin;
        d.cs_s2 = q.cs_s1;
        d.sck_s1 = sck_pin;
        d.sck_s2 = q.sck_s1;
        d.sck_prev = q.sck_s2;
        d.si_s1 = si_pin;
        d.si_s2 = q.si_s1;
        d.start = 1'b0;
        d.stg_wr = 1'b0;
        if (q.cs_s2) begin
            // whole address and whole bytes only, else the command is dropped
            if (q.st == SPI_DATA && q.bits == 3'h0 && !eng_bus.busy) begin // [R04]
                d.start = 1'b1;
                d.buf2 = (q.opcode == OP_LOAD_B2) | (q.opcode == OP_COMP_B2) | (q.opcode == OP_REWR_B2); // [R01] [R06] [R09]
                d.page = page_cfg_256 ? q.addr[PG256_LSB +: PAGE_W] : q.addr[PG264_LSB +: PAGE_W]; // [R02] [R03]
                if (q.opcode == OP_COMP_B1 || q.opcode == OP_COMP_B2) begin
                    d.op = PBOPS_OP_COMP; // [R06]
                end else if (is_rewrite(q.opcode)) begin
                    d.op = q.had_data ? PBOPS_OP_RMW : PBOPS_OP_REWR; // [R11] [R09]
                end else begin
                    d.op = PBOPS_OP_LOAD; // [R01]
                end
            end
            d.st = SPI_IDLE; // [R17]
            d.bits = 3'h0;
            d.bytes = 2'h0;
            d.had_data = 1'b0;
            d.stg_idx = STAGE_IDX_RST;
        end else begin
            unique case (q.st)
                SPI_IDLE: d.st = SPI_OPC;
                SPI_OPC: begin
                    if (sck_rise) begin
                        d.shreg = shifted;
                        d.bits = q.bits + 3'h1;
                        if (q.bits == LAST_BIT) begin
                            d.opcode = shifted;
                            d.sts_sel = 1'b0;
                            if (shifted == OP_STATUS) begin
                                d.st = SPI_STAT; // [R13] [R14]
                            end else if (is_page_cmd(shifted) && !eng_bus.busy) begin
                                d.st = SPI_ADDR; // [R24]
                            end else begin
                                d.st = SPI_SKIP;
                            end
                        end
                    end
                end
                SPI_ADDR: begin
                    if (sck_rise) begin
                        d.addr = {q.addr[22:0], q.si_s2};
                        d.bits = q.bits + 3'h1;
                        if (q.bits == LAST_BIT) begin
                            d.bytes = q.bytes + 2'h1;
                            if (q.bytes + 2'h1 == ADDR_BYTES) begin
                                d.st = SPI_DATA;
                            end
                        end
                    end
                end
                SPI_DATA: begin
                    if (sck_rise) begin
                        d.shreg = shifted;
                        d.bits = q.bits + 3'h1;
                        if (q.bits == LAST_BIT && is_rewrite(q.opcode)) begin
                            d.stg_wr = 1'b1; // [R11]
                            d.stg_byte = shifted;
                            d.stg_idx = q.stg_idx + 9'h001;
                            d.had_data = 1'b1;
                        end
                    end
                end
                SPI_STAT: begin
                    if (sck_fall) begin
                        d.bits = q.bits + 3'h1;
                        if (q.bits == 3'h0) begin
                            // sample each byte afresh so a poll sees ready change
                            d.so = q.sts_sel ? sts2[STS_RDY_BIT] : sts1[STS_RDY_BIT]; // [R15] [R16]
                            d.sts_byte = q.sts_sel ? {sts2[6:0], 1'b0} : {sts1[6:0], 1'b0};
                        end else begin
                            d.so = q.sts_byte[7];
                            d.sts_byte = {q.sts_byte[6:0], 1'b0};
                        end
                        if (q.bits == LAST_BIT) begin
                            d.sts_sel = ~q.sts_sel; // [R15]
                        end
                    end
                end
                SPI_SKIP: d.st = SPI_SKIP;
                default: d.st = SPI_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '{cs_s1: 1'b1, cs_s2: 1'b1, st: SPI_IDLE, bits: 3'h0, bytes: 2'h0, shreg: 8'h00,
                   opcode: 8'h00, addr: 24'h000000, sts_byte: 8'h00, stg_idx: STAGE_IDX_RST,
                   stg_byte: 8'h00, op: PBOPS_OP_LOAD, page: '0, default: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign eng_bus.start = q.start;
    assign eng_bus.op = q.op;
    assign eng_bus.buf2 = q.buf2;
    assign eng_bus.page = q.page;
    assign so_o = q.so;
    assign so_oe = (q.st == SPI_STAT); // [R17]
    assign stage_wr = q.stg_wr;
    assign stage_idx = q.stg_idx;
    assign stage_byte = q.stg_byte;

    pbops_engine u_engine (
        .core_clk(core_clk),
        .rst(rst),
        .ctl(eng_bus.eng),
        .arr_req(arr_req),
        .arr_kind(arr_kind),
        .arr_buf2(arr_buf2),
        .arr_page(arr_page),
        .arr_done(arr_done),
        .arr_mismatch(arr_mismatch),
        .arr_fault(arr_fault),
        .arr_abort(arr_abort)
    );

    a_start_on_rise: assert property (@(posedge core_clk) disable iff (rst) // [R04]
        q.start |-> q.cs_s2 && $past(q.st) == SPI_DATA && q.st == SPI_IDLE) else $error("start without cs rise");
    a_float_on_release: assert property (@(posedge core_clk) disable iff (rst) // [R17]
        q.cs_s2 |=> !so_oe) else $error("so still driven after release");
    a_load_buffer_sel: assert property (@(posedge core_clk) disable iff (rst) // [R01]
        q.start && q.op == PBOPS_OP_LOAD |-> q.buf2 == ($past(q.opcode) == OP_LOAD_B2)) else $error("load buffer wrong");
    a_page_264_map: assert property (@(posedge core_clk) disable iff (rst) // [R02]
        q.start && !page_cfg_256 && $stable(page_cfg_256) |-> q.page == $past(q.addr[20:9])) else $error("264 page wrong");
    a_page_256_map: assert property (@(posedge core_clk) disable iff (rst) // [R03]
        q.start && page_cfg_256 && $stable(page_cfg_256) |-> q.page == $past(q.addr[19:8])) else $error("256 page wrong");
    a_merge_select: assert property (@(posedge core_clk) disable iff (rst) // [R11]
        q.start && is_rewrite($past(q.opcode)) |-> (q.op == PBOPS_OP_RMW) == $past(q.had_data)) else $error("merge select wrong");
    a_status_wrap: assert property (@(posedge core_clk) disable iff (rst) // [R15]
        q.st == SPI_STAT && !q.cs_s2 && sck_fall && q.bits == LAST_BIT |=> q.sts_sel != $past(q.sts_sel)) else $error("no byte wrap");
    a_ready_first_bit: assert property (@(posedge core_clk) disable iff (rst) // [R16]
        q.st == SPI_STAT && !q.cs_s2 && sck_fall && q.bits == 3'h0 |=> so_o == $past(ready)) else $error("ready bit wrong");

    sequence s_frame_end;
        q.cs_s2 && q.st == SPI_DATA && q.bits == 3'h0 && !eng_bus.busy;
    endsequence

    sequence s_launch;
        q.start ##1 (eng_bus.busy && arr_req);
    endsequence

    sequence s_opcode_done;
        q.st == SPI_OPC && !q.cs_s2 && sck_rise && q.bits == LAST_BIT;
    endsequence

    a_launch_on_rise: assert property (@(posedge core_clk) disable iff (rst) // [R04] [R05]
        s_frame_end |=> s_launch)
        else $error("no launch after frame end");

    a_status_accept: assert property (@(posedge core_clk) disable iff (rst) // [R14]
        s_opcode_done ##0 (shifted == OP_STATUS) |=> q.st == SPI_STAT && so_oe)
        else $error("status read refused");

    // busy page commands are dropped, not queued
    a_busy_cmd_skip: assert property (@(posedge core_clk) disable iff (rst) // [R05]
        s_opcode_done ##0 (shifted != OP_STATUS && eng_bus.busy) |=> q.st == SPI_SKIP)
        else $error("command taken while busy");

    a_page_cmd_addr: assert property (@(posedge core_clk) disable iff (rst) // [R06] [R09]
        s_opcode_done ##0 (is_page_cmd(shifted) && !eng_bus.busy) |=> q.st == SPI_ADDR)
        else $error("page command not taken");

    a_load_request: assert property (@(posedge core_clk) disable iff (rst) // [R01]
        q.start && q.op == PBOPS_OP_LOAD |=> arr_req && arr_kind == ARR_FETCH && arr_page == $past(q.page))
        else $error("load request wrong");

    a_compare_kind: assert property (@(posedge core_clk) disable iff (rst) // [R07]
        q.start && q.op == PBOPS_OP_COMP |=> arr_req && arr_kind == ARR_COMPARE)
        else $error("compare request wrong");

    a_merge_strobe: assert property (@(posedge core_clk) disable iff (rst) // [R11]
        stage_wr |-> $past(q.st) == SPI_DATA && is_rewrite(q.opcode))
        else $error("merge strobe outside data");

    a_byte2_rsvd_zero: assert property (@(posedge core_clk) disable iff (rst) // [R22]
        q.st == SPI_STAT && !q.cs_s2 && sck_fall && q.bits == 3'h1 && q.sts_sel |=> !so_o)
        else $error("reserved status bit set");

    a_density_out: assert property (@(posedge core_clk) disable iff (rst) // [R18]
        q.st == SPI_STAT && !q.cs_s2 && sck_fall && q.bits == 3'h2 && !q.sts_sel |=> so_o == DENSITY_CODE[3])
        else $error("density bit wrong");
endmodule : pbops_top

//--- pbops_host.sv
/*
 * link host model: frames opcodes, addresses and data onto the pins, reads so.
 * assumes mode 0, a 320 ns link clock that stands low outside frames.
 */
`timescale 1ns/100ps
module pbops_host (
    output logic cs_n_pin, // chip select, low active
    output logic sck_pin, // link clock
    output logic si_pin, // data toward the device
    input wire logic so_o, // device data out
    input wire logic so_oe // device output enable
);
    logic so_last = 1'b0;
    // no pull on so: a released line shows the inverse of its last value
    wire so_line = so_oe ? so_o : ~so_last;
    always @(so_o or so_oe) if (so_oe) so_last = so_o;
    initial begin
        cs_n_pin = 1'b1;
        sck_pin = 1'b0;
        si_pin = 1'b0;
    end
    task automatic frame_open();
        cs_n_pin = 1'b0;
        #160;
    endtask : frame_open
    task automatic put_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            sck_pin = 1'b0;
            si_pin = b[7-i]; // msb first
            #160;
            sck_pin = 1'b1;
            #160;
        end
    endtask : put_byte
    task automatic get_bits(input int n, output logic [7:0] b);
        b = 8'h00;
        for (int i = 0; i < n; i++) begin
            sck_pin = 1'b0;
            si_pin = ~si_pin;
            #160;
            sck_pin = 1'b1;
            #150;
            b[n-1-i] = so_line; // late in the high phase, well after the shift
            #10;
        end
    endtask : get_bits
    task automatic frame_close();
        sck_pin = 1'b0;
        #160;
        cs_n_pin = 1'b1;
        si_pin = ~si_pin;
        #320;
    endtask : frame_close
endmodule : pbops_host

//--- pbops_top_bench.sv
/*
 * self-checking bench for pbops_top: host model on the link, array model here.
 * assumes core_clk 40 ns; the array answers each request after a long delay.
 */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module pbops_top_bench;
    import pbops_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n_pin, sck_pin, si_pin, so_o, so_oe, stage_wr, arr_req, arr_buf2;
    logic sector_protect_en = 1'b0, page_cfg_256 = 1'b0;
    logic [8:0] stage_idx;
    logic [7:0] stage_byte;
    logic [1:0] arr_kind;
    logic [PAGE_W-1:0] arr_page;
    logic arr_done = 1'b0, arr_mismatch = 1'b0, arr_fault = 1'b0, arr_abort = 1'b0;
    logic mis_set = 1'b0, flt_set = 1'b0, abt_set = 1'b0, exp_comp = 1'b0, exp_flt = 1'b0;
    logic [14:0] req_q[$];
    logic [16:0] stg_q[$];
    logic [31:0] rng = 32'hbe72;
    logic [7:0] ops[6] = '{OP_LOAD_B1, OP_LOAD_B2, OP_COMP_B1, OP_COMP_B2, OP_REWR_B1, OP_REWR_B2};
    int err_total = 0;
    int compares = 0;
    always #20 core_clk = ~core_clk;
    pbops_host host (.cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin), .so_o(so_o), .so_oe(so_oe));
    pbops_top DUT (.core_clk(core_clk), .rst(rst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin),
        .so_o(so_o), .so_oe(so_oe), .sector_protect_en(sector_protect_en), .page_cfg_256(page_cfg_256),
        .stage_wr(stage_wr), .stage_idx(stage_idx), .stage_byte(stage_byte), .arr_req(arr_req),
        .arr_kind(arr_kind), .arr_buf2(arr_buf2), .arr_page(arr_page), .arr_done(arr_done),
        .arr_mismatch(arr_mismatch), .arr_fault(arr_fault), .arr_abort(arr_abort));
    function automatic logic [31:0] nxt();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : nxt
    function automatic logic [7:0] exp_b1(input logic rdy);
        return {rdy, exp_comp, DENSITY_CODE, sector_protect_en, page_cfg_256};
    endfunction : exp_b1
    function automatic logic [7:0] exp_b2(input logic rdy);
        return {rdy, 1'b0, exp_flt, 5'h00};
    endfunction : exp_b2
    // array model: slow enough that status polls see busy
    task automatic array_answer(input logic [1:0] k);
        repeat (250 + nxt() % 40) @(posedge core_clk);
        #1;
        arr_done = 1'b1;
        arr_mismatch = (k == ARR_COMPARE) & mis_set;
        arr_fault = (k == ARR_PROGRAM) & flt_set;
        arr_abort = (k == ARR_PROGRAM) & abt_set;
        @(posedge core_clk);
        #1;
        {arr_done, arr_mismatch, arr_fault, arr_abort} = 4'h0;
    endtask : array_answer
    always @(posedge core_clk) begin
        if (arr_req) begin
            req_q.push_back({arr_kind, arr_buf2, arr_page});
            fork
                array_answer(arr_kind);
            join_none
        end
        if (stage_wr) stg_q.push_back({stage_idx, stage_byte});
    end
    task automatic rd_status(output logic [7:0] b1, output logic [7:0] b2);
        host.frame_open();
        host.put_byte(OP_STATUS);
        host.get_bits(8, b1);
        host.get_bits(8, b2);
        host.frame_close();
    endtask : rd_status
    task automatic page_cmd(input logic [7:0] op, input logic [11:0] pg, input logic [15:0] dat,
            input int nd, input int na);
        logic [31:0] r;
        logic [23:0] adr;
        r = nxt();
        adr = page_cfg_256 ? {r[23:20], pg, r[7:0]} : {r[23:21], pg, r[8:0]};
        host.frame_open();
        host.put_byte(op);
        for (int i = 0; i < na; i++) host.put_byte(adr[23-8*i -: 8]);
        for (int i = 0; i < nd; i++) host.put_byte(dat[15-8*i -: 8]);
        host.frame_close();
    endtask : page_cmd
    task automatic wait_ready();
        logic [7:0] b1, b2;
        for (int i = 0; i < 30; i++) begin
            rd_status(b1, b2);
            if (b1[STS_RDY_BIT] === 1'b1) break;
        end
        `CHK("ready byte1", exp_b1(1'b1), b1)
        `CHK("ready byte2", exp_b2(1'b1), b2)
    endtask : wait_ready
    task automatic do_op(input int k, input int nd);
        logic [11:0] pg;
        logic [15:0] dat;
        logic [31:0] r;
        logic [7:0] b1, b2;
        logic [1:0] k0;
        r = nxt();
        pg = r[11:0];
        dat = r[31:16];
        {mis_set, flt_set, abt_set} = r[14:12];
        page_cmd(ops[k], pg, dat, nd, 3);
        rd_status(b1, b2);
        `CHK("busy byte1", exp_b1(1'b0), b1)
        `CHK("busy byte2", exp_b2(1'b0), b2)
        if (k / 2 == 1) exp_comp = mis_set;
        if (k / 2 == 2) exp_flt = flt_set & ~abt_set;
        wait_ready();
        k0 = (k / 2 == 1) ? ARR_COMPARE : (nd > 0 ? ARR_FETCH_MERGE : ARR_FETCH);
        `CHK("request count", (k / 2 == 2) ? 2 : 1, req_q.size())
        `CHK("first request", {k0, k[0], pg}, req_q.pop_front())
        if (k / 2 == 2) `CHK("program request", {ARR_PROGRAM, k[0], pg}, req_q.pop_front())
        `CHK("merge bytes", nd, stg_q.size())
        for (int i = 0; i < nd; i++) `CHK("merge byte", {9'(i + 1), dat[15-8*i -: 8]}, stg_q.pop_front())
        req_q.delete();
        stg_q.delete();
    endtask : do_op
    task automatic give_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        #(40 * 95000);
        err_total++;
        give_verdict();
    end
    initial begin
        logic [7:0] b;
        logic [31:0] r;
        repeat (12) @(posedge core_clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        for (int m = 0; m < 4; m++) begin
            {sector_protect_en, page_cfg_256} = 2'(m);
            host.frame_open();
            host.put_byte(OP_STATUS);
            for (int p = 0; p < 4; p++) begin
                host.get_bits(8, b);
                `CHK("status pass", (p % 2) ? exp_b2(1'b1) : exp_b1(1'b1), b)
            end
            host.frame_close();
        end
        // cut mid-byte: output must float within 320 ns of release
        host.frame_open();
        host.put_byte(OP_STATUS);
        host.get_bits(3, b);
        `CHK("driving so", 1'b1, so_oe)
        host.frame_close();
        `CHK("released so", 1'b0, so_oe)
        // too few address bytes: nothing starts
        page_cmd(OP_LOAD_B1, 12'h0a5, 16'h0000, 0, 2);
        repeat (20) @(posedge core_clk);
        #1;
        `CHK("short frame", 0, req_q.size())
        for (int it = 0; it < 26; it++) begin
            r = nxt();
            {sector_protect_en, page_cfg_256} = r[9:8];
            if (it < 6) do_op(it, 0);
            else if (it < 10) do_op(4 + it % 2, 1 + it % 2);
            else do_op(r % 6, (r % 6 >= 4 && r[4]) ? 1 + r[5] : 0);
        end
        give_verdict();
    end
endmodule : pbops_top_bench
